// *** rtl/adc_readout_pkg.sv ***
// Constants and types for the conversion and readout block.
// Assumes a 250 MHz system clock; the serial link runs on its own clock.
`default_nettype none
package adc_readout_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS     = 4;
	localparam int CONV_CYCLES       = 19;
	localparam int CONV_CYCLES_MAX   = 20;
	localparam int INT_CLK_PERIOD_NS = 64;
	localparam int INT_CLK_DIV       = INT_CLK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int BUSY_DELAY_NS     = 25;
	localparam int BUSY_DELAY_CYC    = BUSY_DELAY_NS / CLK_PERIOD_NS;
	// ----------------------------------------
	// Shape and reset values
	// ----------------------------------------
	localparam int RESULT_BITS = 16;
	localparam int CHANNELS    = 8;
	localparam int PAIRS       = 4;
	localparam int LANE_BITS   = 2 * RESULT_BITS;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [5:0]  BIT_COUNT_MAX = 6'h3f;
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b01,
		ST_CONVERT = 2'b10
	} conv_state_t;
endpackage : adc_readout_pkg
`default_nettype wire

// *** rtl/adc_conversion_readout.sv ***
// Conversion sequencer with serial and parallel result readout.
// Assumes the host keeps its own timing; serialClock is a separate domain.
`default_nettype none
module adc_conversion_readout #(
	parameter int INT_DIV = adc_readout_pkg::INT_CLK_DIV
) (
	// System
	input  wire logic         clock,
	input  wire logic         rst_n,
	// Conversion control
	input  wire logic [3:0]   pairConversionStart,
	input  wire logic         conversionClockSelect,
	input  wire logic         externalConversionClock,
	input  wire logic [127:0] channelCode,
	output logic              busy,
	// Serial link
	input  wire logic         serialClock,
	input  wire logic         frameSyncN,
	input  wire logic [3:0]   serialDaisyIn,
	output logic [3:0]        serialResultLaneOut,
	output logic [3:0]        serialResultLaneOe,
	// Parallel bus
	input  wire logic         chipSelectN,
	input  wire logic         readStrobeN,
	output logic [15:0]       parallelResultBusOut,
	output logic              parallelResultBusOe
);
	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Both words of a lane shift MSB first, then the daisy chain follows
	function automatic logic laneBit(input logic [15:0] first, input logic [15:0] second,
		input logic [5:0] count, input logic chain);
		logic [3:0] pos;
		pos = ~count[3:0];
		if (count[5]) begin
			return chain;
		end else if (count[4]) begin
			return second[pos];
		end
		return first[pos];
	endfunction : laneBit

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [3:0] startMeta_reg;
	logic [3:0] startSync_reg;
	logic [3:0] startPrev_reg;
	logic       xclkMeta_reg;
	logic       xclkSync_reg;
	logic       xclkPrev_reg;
	logic       csMeta_reg;
	logic       csSync_reg;
	logic       rdMeta_reg;
	logic       rdSync_reg;
	logic       rdPrev_reg;

	always_ff @(posedge clock) begin
		startMeta_reg <= pairConversionStart;
		startSync_reg <= startMeta_reg;
		startPrev_reg <= startSync_reg;
		xclkMeta_reg  <= externalConversionClock;
		xclkSync_reg  <= xclkMeta_reg;
		xclkPrev_reg  <= xclkSync_reg;
		csMeta_reg    <= chipSelectN;
		csSync_reg    <= csMeta_reg;
		rdMeta_reg    <= readStrobeN;
		rdSync_reg    <= rdMeta_reg;
		rdPrev_reg    <= rdSync_reg;
	end

	logic [3:0] startEdge;
	logic       xclkRise;
	logic       rdRise;
	assign startEdge = startSync_reg & ~startPrev_reg;
	assign xclkRise  = xclkSync_reg & ~xclkPrev_reg;
	assign rdRise    = rdSync_reg & ~rdPrev_reg;

	// ----------------------------------------
	// Conversion sequencer
	// ----------------------------------------
	adc_readout_pkg::conv_state_t state_reg;
	adc_readout_pkg::conv_state_t state_next;
	logic [7:0]  divCount_reg;
	logic [7:0]  divCount_next;
	logic [4:0]  convCount_reg;
	logic [4:0]  convCount_next;
	logic        busy_reg;
	logic        busy_next;
	logic [3:0]  pairs_reg;
	logic [3:0]  pairs_next;
	logic [15:0] sample_reg [8];
	logic [15:0] sample_next [8];
	logic [15:0] result_reg [8];
	logic [15:0] result_next [8];
	logic        intTick;
	logic        convTick;

	always_comb begin
		intTick = (divCount_reg == 8'(INT_DIV - 1));
		// Free-running divider: start lands mid-period, giving just over 18 to 19 periods
		convTick = conversionClockSelect ? xclkRise : intTick;
		divCount_next  = intTick ? 8'h00 : divCount_reg + 8'h01;
		state_next     = state_reg;
		convCount_next = convCount_reg;
		busy_next      = busy_reg;
		pairs_next     = pairs_reg;
		sample_next    = sample_reg;
		result_next    = result_reg;
		case (state_reg)
			adc_readout_pkg::ST_IDLE: begin
				if (startEdge != 4'h0) begin
					state_next     = adc_readout_pkg::ST_CONVERT;
					busy_next      = 1'b1;
					convCount_next = 5'h00;
					pairs_next     = startEdge;
					for (int c = 0; c < adc_readout_pkg::CHANNELS; c++) begin
						if (startEdge[c / 2]) begin
							sample_next[c] = channelCode[c * 16 +: 16];
						end
					end
				end
			end
			adc_readout_pkg::ST_CONVERT: begin
				// Starts during a conversion are ignored; no second pipeline
				if (convTick) begin
					if (convCount_reg == 5'(adc_readout_pkg::CONV_CYCLES - 1)) begin
						state_next = adc_readout_pkg::ST_IDLE;
						busy_next  = 1'b0;
						for (int c = 0; c < adc_readout_pkg::CHANNELS; c++) begin
							if (pairs_reg[c / 2]) begin
								result_next[c] = sample_reg[c];
							end
						end
					end else begin
						convCount_next = convCount_reg + 5'h01;
					end
				end
			end
			default: begin
				state_next = adc_readout_pkg::ST_IDLE;
				busy_next  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg     <= adc_readout_pkg::ST_IDLE;
			divCount_reg  <= 8'h00;
			convCount_reg <= 5'h00;
			busy_reg      <= 1'b0;
			pairs_reg     <= 4'h0;
			for (int c = 0; c < adc_readout_pkg::CHANNELS; c++) begin
				sample_reg[c] <= adc_readout_pkg::RESULT_RESET;
				result_reg[c] <= adc_readout_pkg::RESULT_RESET;
			end
		end else begin
			state_reg     <= state_next;
			divCount_reg  <= divCount_next;
			convCount_reg <= convCount_next;
			busy_reg      <= busy_next;
			pairs_reg     <= pairs_next;
			sample_reg    <= sample_next;
			result_reg    <= result_next;
		end
	end

	assign busy = busy_reg;

	// ----------------------------------------
	// Parallel readout
	// ----------------------------------------
	logic [2:0]  wordIdx_reg;
	logic [2:0]  wordIdx_next;
	logic [15:0] parData_reg;
	logic [15:0] parData_next;
	logic        convDone;

	assign convDone = busy_reg & ~busy_next;

	always_comb begin
		wordIdx_next = wordIdx_reg;
		if (convDone) begin
			wordIdx_next = 3'h0;
		end else if (rdRise && !csSync_reg) begin
			wordIdx_next = wordIdx_reg + 3'h1;
		end
		parData_next = result_reg[wordIdx_reg];
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wordIdx_reg <= 3'h0;
			parData_reg <= adc_readout_pkg::RESULT_RESET;
		end else begin
			wordIdx_reg <= wordIdx_next;
			parData_reg <= parData_next;
		end
	end

	// Word is settled before the strobe falls, so only the enable must be fast
	assign parallelResultBusOut = parData_reg;
	// Enable taken straight from the pin: a synchroniser would miss the 10 ns release
	assign parallelResultBusOe  = ~chipSelectN;

	// ----------------------------------------
	// Serial readout (serialClock domain)
	// ----------------------------------------
	// Results only change while busy, when the host holds off framing,
	// so the words are quasi-static to this domain
	logic [5:0] bitCount_reg;
	logic [5:0] bitCount_next;
	logic [3:0] chain_reg;
	logic [3:0] chain_next;

	always_comb begin
		bitCount_next = (bitCount_reg == adc_readout_pkg::BIT_COUNT_MAX) ?
			bitCount_reg : bitCount_reg + 6'h01;
		chain_next = serialDaisyIn;
	end

	// Frame sync clears the count, so the MSB is out before any clock edge
	always_ff @(negedge serialClock or posedge frameSyncN) begin
		if (frameSyncN) begin
			bitCount_reg <= 6'h00;
			chain_reg    <= 4'h0;
		end else begin
			bitCount_reg <= bitCount_next;
			chain_reg    <= chain_next;
		end
	end

	always_comb begin
		for (int k = 0; k < adc_readout_pkg::PAIRS; k++) begin
			serialResultLaneOut[k] = laneBit(result_reg[2 * k], result_reg[2 * k + 1],
				bitCount_reg, chain_reg[k]);
		end
		serialResultLaneOe = {4{~frameSyncN}};
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	localparam int BUSY_MAX = adc_readout_pkg::BUSY_DELAY_CYC;
	localparam int LEN_MIN  = (adc_readout_pkg::CONV_CYCLES - 1) * INT_DIV + 1;
	localparam int LEN_MAX  = adc_readout_pkg::CONV_CYCLES * INT_DIV;
	logic [9:0] busyLen_reg;
	always_ff @(posedge clock) begin
		busyLen_reg <= (!rst_n || !busy_reg) ? 10'h000 : busyLen_reg + 10'h001;
	end

	sequence startSeen;
		!busy_reg && (state_reg == adc_readout_pkg::ST_IDLE) && $rose(pairConversionStart[0]);
	endsequence
	sequence frameRun;
		!frameSyncN && $past(!frameSyncN);
	endsequence

	AST_BUSY_RISE: assert property (@(posedge clock) disable iff (!rst_n)
		startSeen |-> ##[1:BUSY_MAX] busy_reg)
		else $error("busy late after start");
	AST_CONV_LEN: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(busy_reg) && !conversionClockSelect |->
		($past(busyLen_reg) >= 10'(LEN_MIN - 1)) && ($past(busyLen_reg) <= 10'(LEN_MAX)))
		else $error("internal conversion length wrong");
	AST_CLK_SEL: assert property (@(posedge clock) disable iff (!rst_n)
		(state_reg == adc_readout_pkg::ST_CONVERT) && conversionClockSelect && !xclkRise
		|=> $stable(convCount_reg))
		else $error("conversion advanced without external clock");
	AST_BUSY_FALL: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(busy_reg) && $past(pairs_reg[0]) |-> result_reg[0] == sample_reg[0])
		else $error("busy fell before result held");
	AST_PAR_OE: assert property (@(posedge clock) disable iff (!rst_n)
		chipSelectN |-> !parallelResultBusOe)
		else $error("parallel bus driven with chip select high");
	AST_PAR_DATA: assert property (@(posedge clock) disable iff (!rst_n)
		(!csSync_reg && !rdSync_reg && !busy_reg)[*3] |->
		parallelResultBusOut == result_reg[wordIdx_reg])
		else $error("parallel word not valid");
	AST_LANE_TRI: assert property (@(posedge clock) disable iff (!rst_n)
		frameSyncN |-> serialResultLaneOe == 4'h0)
		else $error("lanes driven outside frame");
	AST_LANE_MSB: assert property (@(negedge serialClock) disable iff (frameSyncN)
		bitCount_reg == 6'h00 |-> serialResultLaneOut[0] == result_reg[0][15])
		else $error("first lane bit is not the MSB");
	AST_LANE_NEXT: assert property (@(negedge serialClock) disable iff (frameSyncN)
		(frameRun and (bitCount_reg != 6'h00 && $past(bitCount_reg) < 6'h20)) |->
		bitCount_reg == $past(bitCount_reg) + 6'h01)
		else $error("lane did not advance");
	AST_DAISY: assert property (@(negedge serialClock) disable iff (frameSyncN)
		(frameRun and bitCount_reg[5]) |-> serialResultLaneOut[0] == $past(serialDaisyIn[0]))
		else $error("daisy bit not passed on");
endmodule : adc_conversion_readout
`default_nettype wire

// *** tb/serial_host_model.sv ***
// Host-side model of the serial readout link.
// Assumes lanes change on falling link clock edges and are read before each fall.
`default_nettype none
module serial_host_model (
	// Link outputs
	output logic            serialClock,
	output logic            frameSyncN,
	output logic [3:0]      serialDaisyIn,
	// Link inputs
	input  wire logic [3:0] serialResultLaneOut
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		serialClock = 1'b1;
		frameSyncN = 1'b1;
		serialDaisyIn = 4'h5;
	end
	// 125 ns clock at even duty, held high between frames so no stray edges
	// Two extra falls push the captured daisy bits out on the lanes
	task automatic readFrame(output logic [127:0] cap, output logic [3:0] chainSeen,
			output logic [3:0] chainWant);
		frameSyncN = 1'b0;
		for (int i = 0; i < 34; i++) begin
			#62.5;
			for (int k = 0; k < 4; k++) begin
				if (i < 32) cap[32*k+31-i] = serialResultLaneOut[k];
			end
			if (i == 31) chainWant = serialDaisyIn;
			if (i == 32) chainSeen = serialResultLaneOut;
			serialClock = 1'b0;
			#62.5;
			serialClock = 1'b1;
			serialDaisyIn = ~serialDaisyIn;
		end
		frameSyncN = 1'b1;
	endtask : readFrame
endmodule : serial_host_model
`default_nettype wire

// *** tb/adc_conversion_readout_tb_top.sv ***
// Self-checking bench for the conversion and readout block.
// Assumes the small divider value 4 and a 100 ns external conversion clock.
`default_nettype none
module adc_conversion_readout_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int DIV = 4;
	typedef struct packed {logic [3:0] mask; logic [15:0] base;} row_t;
	row_t rows [4] = '{'{4'hf, 16'h1000}, '{4'h2, 16'h2000}, '{4'h5, 16'h3000}, '{4'h8, 16'h4000}};
	logic         clock, rst_n, conversionClockSelect, externalConversionClock, busy;
	logic         serialClock, frameSyncN, chipSelectN, readStrobeN, parallelResultBusOe, xclkRun;
	logic [3:0]   pairConversionStart, serialDaisyIn, serialResultLaneOut, serialResultLaneOe;
	logic [127:0] channelCode;
	logic [15:0]  parallelResultBusOut;
	logic [15:0]  expWord [8];
	int           err_total, tests_run, cycles;
	adc_conversion_readout #(.INT_DIV(DIV)) i_dut (.clock(clock), .rst_n(rst_n),
		.pairConversionStart(pairConversionStart), .conversionClockSelect(conversionClockSelect),
		.externalConversionClock(externalConversionClock), .channelCode(channelCode), .busy(busy),
		.serialClock(serialClock), .frameSyncN(frameSyncN), .serialDaisyIn(serialDaisyIn),
		.serialResultLaneOut(serialResultLaneOut), .serialResultLaneOe(serialResultLaneOe),
		.chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
		.parallelResultBusOut(parallelResultBusOut), .parallelResultBusOe(parallelResultBusOe));
	serial_host_model i_host (.serialClock(serialClock), .frameSyncN(frameSyncN),
		.serialDaisyIn(serialDaisyIn), .serialResultLaneOut(serialResultLaneOut));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	initial begin
		externalConversionClock = 1'b0;
		forever begin
			#50;
			if (xclkRun) externalConversionClock = ~externalConversionClock;
		end
	end
	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check
	task automatic end_sim();
		$display("checks=%0d errors=%0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			err_total++;
			end_sim();
		end
	end
	// ----------------------------------------
	// Transfers
	// ----------------------------------------
	// Pins raised in late during busy must be ignored, as must code changes
	task automatic convert(input logic [3:0] mask, input logic [3:0] late,
			input logic [15:0] base, input int lo, input int hi);
		int n;
		n = 0;
		for (int c = 0; c < 8; c++) channelCode[16*c +: 16] = base + 16'(c) * 16'h1111;
		pairConversionStart = mask;
		while (busy !== 1'b1 && n < 10) begin
			@(negedge clock);
			n++;
		end
		check(32'(n <= 6), 32'h1);
		repeat (10) @(negedge clock);
		n = n + 10;
		pairConversionStart = mask | late;
		channelCode = ~channelCode;
		while (busy === 1'b1 && n < 3000) begin
			@(negedge clock);
			n++;
		end
		check(32'(n >= lo && n <= hi), 32'h1);
		pairConversionStart = 4'h0;
		for (int c = 0; c < 8; c++) if (mask[c/2]) expWord[c] = base + 16'(c) * 16'h1111;
		repeat (25) @(negedge clock);
	endtask : convert
	task automatic readPar();
		readStrobeN = 1'b0;
		repeat (3) @(negedge clock);
		readStrobeN = 1'b1;
		repeat (6) @(negedge clock);
		chipSelectN = 1'b0;
		#1 check(32'(parallelResultBusOe), 32'h1);
		for (int w = 0; w < 9; w++) begin
			@(negedge clock);
			readStrobeN = 1'b0;
			repeat (2) @(negedge clock);
			check(32'(parallelResultBusOut), 32'(expWord[w%8]));
			readStrobeN = 1'b1;
			repeat (6) @(negedge clock);
		end
		chipSelectN = 1'b1;
		#1 check(32'(parallelResultBusOe), 32'h0);
		repeat (12) @(negedge clock);
	endtask : readPar
	task automatic readSer();
		logic [127:0] cap;
		logic [3:0]   chainSeen;
		logic [3:0]   chainWant;
		i_host.readFrame(cap, chainSeen, chainWant);
		#1 check(32'(serialResultLaneOe), 32'h0);
		for (int k = 0; k < 4; k++) check(cap[32*k +: 32], {expWord[2*k], expWord[2*k+1]});
		check(32'(chainSeen), 32'(chainWant));
		repeat (12) @(negedge clock);
	endtask : readSer
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		chipSelectN = 1'b1;
		readStrobeN = 1'b1;
		pairConversionStart = 4'h0;
		conversionClockSelect = 1'b0;
		channelCode = '0;
		xclkRun = 1'b0;
		for (int c = 0; c < 8; c++) expWord[c] = 16'h0000;
		repeat (10) @(negedge clock);
		check(32'(busy), 32'h0);
		check(32'(parallelResultBusOut), 32'h0);
		rst_n = 1'b1;
		@(negedge clock);
		foreach (rows[r]) begin
			convert(rows[r].mask, 4'h0, rows[r].base, 18 * DIV, 20 * DIV + 2);
			readPar();
			readSer();
		end
		convert(4'h1, 4'h2, 16'h7000, 18 * DIV, 20 * DIV + 2);
		readPar();
		xclkRun = 1'b1;
		convert(4'h4, 4'h0, 16'h8000, 18 * DIV, 20 * DIV + 2);
		conversionClockSelect = 1'b1;
		convert(4'hc, 4'h0, 16'h9000, 450, 502);
		xclkRun = 1'b0;
		conversionClockSelect = 1'b0;
		readPar();
		readSer();
		end_sim();
	end
endmodule : adc_conversion_readout_tb_top
`default_nettype wire
